/* File: rtl/pfv_regs.vh */
`ifndef PFV_REGS_VH
`define PFV_REGS_VH

// ----------------------------------------
// Register map (word aligned byte addresses)
// ----------------------------------------
`define PFV_ADDR_CTRL      12'h000
`define PFV_ADDR_THRESH    12'h004
`define PFV_ADDR_HYST      12'h008
`define PFV_ADDR_STATUS    12'h00C
`define PFV_ADDR_IDLE      12'h010
`define PFV_ADDR_RESULT    12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFV_CTRL_ENABLE    0
`define PFV_CTRL_BURSTOFF  1
`define PFV_CTRL_SCALE_LSB 8
`define PFV_CTRL_SCALE_MSB 15

// ----------------------------------------
// Reset values and fixed constants
// ----------------------------------------
`define PFV_RST_CTRL       32'h0000_0000
`define PFV_RST_THRESH     32'h0000_0000
`define PFV_RST_HYST       8'h04
`define PFV_RST_IDLE       16'h0000
`define PFV_LEVEL_MAX      3'h6
`define PFV_OC_TRIP_LIMIT  2'h3
`define PFV_HYST_RIPPLE    8'h0C
`define PFV_FAST_DEV_PCT   8'h03
`define PFV_PCT_SCALE      16'h0064
`define PFV_CMP_COUNT      6
`define PFV_BYTE_CMPS      4
`define PFV_UPPER_STEP     5

// ----------------------------------------
// Timing (ns) and derived cycle counts
// ----------------------------------------
`define PFV_CLK_NS         4
`define PFV_SAMPLE_WAIT_NS 20000
`define PFV_SAMPLE_CYC     ((`PFV_SAMPLE_WAIT_NS + `PFV_CLK_NS - 1) / `PFV_CLK_NS)
`define PFV_WINDOW_NS      40000000
`define PFV_WINDOW_CYC     (`PFV_WINDOW_NS / `PFV_CLK_NS)
`define PFV_FAULT_NS       400000000
`define PFV_FAULT_CYC      (`PFV_FAULT_NS / `PFV_CLK_NS)

`endif

/* File: rtl/pfv_core.v */
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pfv_regs.vh"

module pfv_core #(
    parameter WINDOW_CYC = `PFV_WINDOW_CYC,
    parameter FAULT_CYC  = `PFV_FAULT_CYC,
    parameter SAMPLE_CYC = `PFV_SAMPLE_CYC
) (
    input  wire        core_clk,         // 250 MHz clock
    input  wire        reset,            // Sync reset, high
    input  wire [11:0] haddr,            // AHB address
    input  wire [1:0]  htrans,           // AHB transfer type
    input  wire        hwrite,           // AHB write
    input  wire [2:0]  hsize,            // AHB size
    input  wire        hsel,             // AHB select
    input  wire        hready,           // AHB ready in
    input  wire [31:0] hwdata,           // AHB write data
    output reg  [31:0] hrdata,           // AHB read data
    output reg         hreadyout,        // AHB ready out
    output reg         hresp,            // AHB response
    input  wire [7:0]  lineLevel,        // Reconstructed line peak code
    input  wire [7:0]  compWord,         // Compensation node code
    input  wire [7:0]  outSense,         // Output sense code
    input  wire [7:0]  gatePinLevel,     // Gate pin voltage code
    input  wire        valley,           // Drain valley detect
    input  wire        grossOc,          // Gross overcurrent comparator
    input  wire        cycleEnd,         // Switching cycle end pulse
    output reg  [2:0]  lineGain,         // Line gain level
    output reg  [15:0] scaledComp,       // Gain-scaled compensation
    output reg  [2:0]  valleyDelay,      // Valley turn-on delay code
    output reg         senseCurrentOn,   // Delay sense current enable
    output reg         gateDrive,        // Cycle start request
    output reg         ampFast,          // Amplifier 6x gain
    output reg         longFault         // Long fault active
);
    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    localparam ST_HALT  = 4'b0001;
    localparam ST_READ  = 4'b0010;
    localparam ST_OFF   = 4'b0100;
    localparam ST_RUN   = 4'b1000;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] ctrl;
    reg [31:0] thresh;
    reg [7:0]  hyst;
    reg [15:0] idleBase;
    reg        dpWrite;
    reg        dpRead;
    reg [11:0] dpAddr;

    reg [7:0]  lineS1;
    reg [7:0]  lineS2;
    reg [7:0]  compS1;
    reg [7:0]  compS2;
    reg [7:0]  outS1;
    reg [7:0]  outS2;
    reg [7:0]  gateS1;
    reg [7:0]  gateS2;
    reg        valS1;
    reg        valS2;
    reg        valPrev;
    reg        ocS1;
    reg        ocS2;
    reg        endS1;
    reg        endS2;

    reg [3:0]  state;
    reg [31:0] timer;
    reg [31:0] windowCnt;
    reg [2:0]  peakLevel;
    reg [1:0]  ocCount;
    reg        dcmMode;
    reg [15:0] idleCnt;
    reg        idleDone;

    wire [2:0] rawLevel;
    wire       valleyEdge = valS2 & ~valPrev;
    wire [7:0] scaleRef  = ctrl[`PFV_CTRL_SCALE_MSB:`PFV_CTRL_SCALE_LSB];

    // ----------------------------------------
    // Line level compare bank
    // ----------------------------------------
    // Level above which line sits; hysteresis lowers thresholds of held levels
    function [2:0] levelOf;
        input [7:0]  lvl;
        input [31:0] th;
        input [7:0]  hy;
        input [2:0]  cur;
        integer k;
        reg [7:0] t;
        begin
            levelOf = 3'h0;
            for (k = 0; k < `PFV_CMP_COUNT; k = k + 1) begin
                t = (k < `PFV_BYTE_CMPS) ? th[k*8 +: 8] :
                    th[31:24] + ({5'h00, k[2:0]} << `PFV_UPPER_STEP);
                if (k < cur && t > hy)
                    t = t - hy;
                if (lvl >= t)
                    levelOf = k[2:0] + 3'h1;
            end
        end
    endfunction

    assign rawLevel = levelOf(lineS2, thresh, hyst, lineGain);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            lineS1  <= 8'h00;
            lineS2  <= 8'h00;
            compS1  <= 8'h00;
            compS2  <= 8'h00;
            outS1   <= 8'h00;
            outS2   <= 8'h00;
            gateS1  <= 8'h00;
            gateS2  <= 8'h00;
            valS1   <= 1'b0;
            valS2   <= 1'b0;
            valPrev <= 1'b0;
            ocS1    <= 1'b0;
            ocS2    <= 1'b0;
            endS1   <= 1'b0;
            endS2   <= 1'b0;
        end else begin
            lineS1  <= lineLevel;
            lineS2  <= lineS1;
            compS1  <= compWord;
            compS2  <= compS1;
            outS1   <= outSense;
            outS2   <= outS1;
            gateS1  <= gatePinLevel;
            gateS2  <= gateS1;
            valS1   <= valley;
            valS2   <= valS1;
            valPrev <= valS2;
            ocS1    <= grossOc;
            ocS2    <= ocS1;
            endS1   <= cycleEnd;
            endS2   <= endS1;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            dpWrite   <= 1'b0;
            dpRead    <= 1'b0;
            dpAddr    <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            ctrl      <= `PFV_RST_CTRL;
            thresh    <= `PFV_RST_THRESH;
            hyst      <= `PFV_RST_HYST;
            idleBase  <= `PFV_RST_IDLE;
        end else begin
            dpWrite <= hsel & hready & htrans[1] & hwrite;
            dpRead  <= hsel & hready & htrans[1] & ~hwrite;
            if (hsel & hready & htrans[1])
                dpAddr <= haddr;
            if (dpWrite) begin
                if (dpAddr == `PFV_ADDR_CTRL)
                    ctrl <= hwdata;
                else if (dpAddr == `PFV_ADDR_THRESH)
                    thresh <= hwdata;
                else if (dpAddr == `PFV_ADDR_HYST)
                    hyst <= hwdata[7:0];
                else if (dpAddr == `PFV_ADDR_IDLE)
                    idleBase <= hwdata[15:0];
            end
            // Read data registered at address phase, valid in data phase
            if (hsel & hready & htrans[1] & ~hwrite) begin
                if (haddr == `PFV_ADDR_CTRL)
                    hrdata <= ctrl;
                else if (haddr == `PFV_ADDR_THRESH)
                    hrdata <= thresh;
                else if (haddr == `PFV_ADDR_HYST)
                    hrdata <= {24'h00_0000, hyst};
                else if (haddr == `PFV_ADDR_STATUS)
                    hrdata <= {16'h0000, ampFast, longFault, dcmMode, ocCount,
                               valleyDelay, state, 1'b0, lineGain};
                else if (haddr == `PFV_ADDR_IDLE)
                    hrdata <= {16'h0000, idleBase};
                else if (haddr == `PFV_ADDR_RESULT)
                    hrdata <= {16'h0000, scaledComp};
                else
                    hrdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Sequencer and fault
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            state          <= ST_HALT;
            timer          <= 32'h0000_0000;
            valleyDelay    <= 3'h0;
            senseCurrentOn <= 1'b0;
            ocCount        <= 2'h0;
            longFault      <= 1'b0;
        end else begin
            case (state)
                ST_HALT: begin
                    senseCurrentOn <= 1'b0;
                    if (longFault) begin
                        if (timer >= FAULT_CYC - 1) begin
                            longFault <= 1'b0;
                            timer     <= 32'h0000_0000;
                        end else begin
                            timer <= timer + 32'h0000_0001;
                        end
                    end else if (ctrl[`PFV_CTRL_ENABLE]) begin
                        state          <= ST_READ;
                        senseCurrentOn <= 1'b1;
                        timer          <= 32'h0000_0000;
                    end
                end
                ST_READ: begin
                    if (timer >= SAMPLE_CYC - 1) begin
                        valleyDelay    <= gateS2[7:5];
                        senseCurrentOn <= 1'b0;
                        state          <= ST_OFF;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                ST_OFF: begin
                    if (ctrl[`PFV_CTRL_ENABLE] & ~ctrl[`PFV_CTRL_BURSTOFF])
                        state <= ST_RUN;
                end
                default: begin
                    if (~ctrl[`PFV_CTRL_ENABLE] | ctrl[`PFV_CTRL_BURSTOFF])
                        state <= ST_OFF;
                    if (endS2) begin
                        if (ocS2 && ocCount == `PFV_OC_TRIP_LIMIT - 2'h1) begin
                            longFault <= 1'b1;
                            ocCount   <= 2'h0;
                            timer     <= 32'h0000_0000;
                            state     <= ST_HALT;
                        end else if (ocS2) begin
                            ocCount <= ocCount + 2'h1;
                        end else begin
                            ocCount <= 2'h0;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Line gain peak detector
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            lineGain  <= 3'h0;
            peakLevel <= 3'h0;
            windowCnt <= 32'h0000_0000;
        end else if (state != ST_RUN) begin
            lineGain  <= rawLevel;
            peakLevel <= 3'h0;
        end else begin
            if (windowCnt >= WINDOW_CYC - 1) begin
                windowCnt <= 32'h0000_0000;
                peakLevel <= 3'h0;
                lineGain  <= (rawLevel > peakLevel) ? rawLevel : peakLevel;
            end else begin
                windowCnt <= windowCnt + 32'h0000_0001;
                if (rawLevel > peakLevel)
                    peakLevel <= rawLevel;
                if (rawLevel > lineGain)
                    lineGain <= rawLevel;
            end
        end
    end

    // ----------------------------------------
    // Scaling, idle time, valley alignment, amplifier
    // ----------------------------------------
    wire [15:0] gainMul   = {8'h00, compS2} * {13'h0000, `PFV_LEVEL_MAX - lineGain + 3'h1};
    wire [15:0] hystBand  = ({8'h00, scaleRef} * {8'h00, `PFV_HYST_RIPPLE}) / `PFV_PCT_SCALE;
    wire [15:0] devBand   = ({8'h00, scaleRef} * {8'h00, `PFV_FAST_DEV_PCT}) / `PFV_PCT_SCALE;
    wire [15:0] scaledRef = {8'h00, scaleRef};
    wire [15:0] outWide   = {8'h00, outS2};

    always @(posedge core_clk) begin
        if (reset) begin
            scaledComp <= 16'h0000;
            dcmMode    <= 1'b0;
            idleCnt    <= 16'h0000;
            idleDone   <= 1'b0;
            gateDrive  <= 1'b0;
            ampFast    <= 1'b0;
        end else begin
            scaledComp <= gainMul;
            // Enter DCM below reference, leave only above reference plus band
            if (gainMul < scaledRef)
                dcmMode <= 1'b1;
            else if (gainMul > scaledRef + hystBand)
                dcmMode <= 1'b0;
            ampFast <= (outWide > scaledRef + devBand) ||
                       (outWide + devBand < scaledRef);
            gateDrive <= 1'b0;
            if (state != ST_RUN) begin
                idleCnt  <= 16'h0000;
                idleDone <= 1'b0;
            end else if (!idleDone) begin
                // Idle saturates at zero; a plain difference would wrap and stall
                if (!dcmMode || {1'b0, idleCnt} + {1'b0, gainMul} >= {1'b0, idleBase})
                    idleDone <= 1'b1;
                else
                    idleCnt <= idleCnt + 16'h0001;
            end else if (valleyEdge) begin
                gateDrive <= 1'b1;
                idleCnt   <= 16'h0000;
                idleDone  <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/pfv_core_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pfv_core_chk #(
    parameter SAMPLE_CYC = 5000
) (
    input wire logic       core_clk,       // Core clock
    input wire logic       reset,          // Sync reset
    input wire logic       hreadyout,      // Bus ready
    input wire logic       hresp,          // Bus response
    input wire logic       valley,         // Valley detect
    input wire logic [2:0] lineGain,       // Gain level
    input wire logic [2:0] valleyDelay,    // Delay code
    input wire logic       senseCurrentOn, // Sense current on
    input wire logic       gateDrive,      // Cycle start
    input wire logic       longFault       // Long fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    int senseRun;
    // ----------------------------------------
    // Length of the current resistor read
    // ----------------------------------------
    always @(posedge core_clk) begin
        senseRun <= (reset || !senseCurrentOn) ? 0 : senseRun + 1;
    end
    sequence s_readStart;
        $rose(senseCurrentOn);
    endsequence
    sequence s_recentValley;
        $past(valley, 2) || $past(valley, 3) || $past(valley, 4);
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_gain_range: assert property (lineGain <= 3'h6)
        else $error("gain level out of range");
    chk_gate_pulse: assert property (gateDrive |=> !gateDrive)
        else $error("cycle start longer than one cycle");
    chk_gate_valley: assert property (gateDrive |-> s_recentValley)
        else $error("cycle start without a valley");
    chk_read_hold: assert property (s_readStart |-> senseCurrentOn [*8])
        else $error("sense current dropped early");
    chk_read_exact: assert property ($fell(senseCurrentOn) |-> senseRun == SAMPLE_CYC)
        else $error("resistor read length wrong");
    chk_fault_quiet: assert property (longFault |-> !gateDrive && !senseCurrentOn)
        else $error("activity during long fault");
    chk_delay_kept: assert property ($changed(valleyDelay) |->
        senseCurrentOn || $past(senseCurrentOn) || $past(senseCurrentOn, 2))
        else $error("delay code changed outside a read");
endmodule
`default_nettype wire

/* File: dv/pfv_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfv_stage_model (
    input  wire logic       core_clk,       // Core clock
    input  wire logic       reset,          // Sync reset
    input  wire logic       gateDrive,      // Cycle start from core
    input  wire logic       senseCurrentOn, // Sense current from core
    input  wire logic       ocMode,         // Bench asks for gross trips
    input  wire logic [7:0] pinCode,        // Resistor voltage code
    output var  logic       valley,         // Drain valley
    output var  logic       cycleEnd,       // Cycle end
    output var  logic       grossOc,        // Gross overcurrent
    output var  logic [7:0] gatePinLevel    // Gate pin voltage
);
    logic [3:0] ring;
    logic [3:0] onCnt;
    // Drain keeps ringing with a 16 cycle period, valley for 6 of them
    always @(posedge core_clk) begin
        ring <= reset ? 4'h0 : ring + 4'h1;
        valley <= ring >= 4'hA;
        onCnt <= reset ? 4'h0 : (gateDrive ? 4'h8 : onCnt - (onCnt != 4'h0));
        cycleEnd <= onCnt == 4'h1;
        grossOc <= ocMode && onCnt != 4'h0 && onCnt <= 4'h2;
        // Undriven pin inverts each cycle, so a sample an odd number of cycles late cannot look right
        gatePinLevel <= reset ? 8'h00 : (senseCurrentOn ? pinCode : ~gatePinLevel);
    end
endmodule
`default_nettype wire

/* File: dv/tb_pfc_feedforward_valley_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pfc_feedforward_valley_timing;
    localparam int SAMP = 20;
    logic        core_clk = 0, reset = 1, hwrite = 0, ocMode = 0;
    logic [11:0] haddr    = 12'h000;
    logic [1:0]  htrans   = 2'b00;
    logic [31:0] hwdata   = 32'h0000_0000;
    logic [7:0]  lineLevel = 8'h00, compWord = 8'h50, outSense = 8'h64, pinCode = 8'hA7;
    wire  [31:0] hrdata;
    wire  [15:0] scaledComp;
    wire  [7:0]  gatePinLevel;
    wire  [2:0]  lineGain, valleyDelay;
    wire         hreadyout, hresp, valley, grossOc, cycleEnd, senseCurrentOn;
    wire         gateDrive, ampFast, longFault;
    int          mismatches = 0, totalChecks = 0;
    initial forever #2 core_clk = ~core_clk;
    pfv_core #(.WINDOW_CYC(64), .FAULT_CYC(200), .SAMPLE_CYC(SAMP)) dut (
        .core_clk(core_clk), .reset(reset), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hsel(1'b1), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .lineLevel(lineLevel), .compWord(compWord), .outSense(outSense),
        .gatePinLevel(gatePinLevel), .valley(valley), .grossOc(grossOc),
        .cycleEnd(cycleEnd), .lineGain(lineGain), .scaledComp(scaledComp),
        .valleyDelay(valleyDelay), .senseCurrentOn(senseCurrentOn),
        .gateDrive(gateDrive), .ampFast(ampFast), .longFault(longFault));
    pfv_stage_model stage (
        .core_clk(core_clk), .reset(reset), .gateDrive(gateDrive),
        .senseCurrentOn(senseCurrentOn), .ocMode(ocMode), .pinCode(pinCode),
        .valley(valley), .cycleEnd(cycleEnd), .grossOc(grossOc),
        .gatePinLevel(gatePinLevel));
    // ----------------------------------------
    // Checking and bus helpers
    // ----------------------------------------
    task printVerdict;
        if (mismatches == 0 && totalChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task expire(input logic ok);
        if (!ok) begin
            mismatches++;
            printVerdict;
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task waitReady;
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        expire(n < 20);
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        waitReady;
        htrans <= 2'b00;
        hwdata <= d;
        waitReady;
        q = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0000_0000, q);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task testReset;
        logic [31:0] q;
        rd(12'h00C, q);
        check(q & 32'h0000_00F0, 32'h0000_0010);
        rd(12'h008, q);
        check(q, 32'h0000_0004);
        rd(12'h020, q);
        check(q, 32'h0000_0000);
        wr(12'h010, 32'h0000_0020);
        rd(12'h010, q);
        check(q, 32'h0000_0020);
    endtask
    task testStartup;
        logic [31:0] q;
        int n, k;
        wr(12'h004, 32'h4030_2010);
        wr(12'h000, 32'h0000_6401);
        for (n = 0; n < 100 && senseCurrentOn !== 1'b1; n++) tick(1);
        expire(n < 100);
        for (k = 0; k < 100 && senseCurrentOn === 1'b1; k++) tick(1);
        check(32'(k), 32'(SAMP));
        check(32'(valleyDelay), 32'h0000_0005);
        for (n = 0; n < 30; n++) begin
            rd(12'h00C, q);
            if (q[7:4] === 4'h8) break;
        end
        check(q & 32'h0000_00F0, 32'h0000_0080);
    endtask
    task automatic testAmp;
        logic [7:0] lvl [5] = '{8'h64, 8'h6E, 8'h61, 8'h68, 8'h60};
        logic       fast [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 5; i++) begin
            outSense <= lvl[i];
            tick(6);
            check(32'(ampFast), 32'(fast[i]));
        end
    endtask
    task waitGain(input logic [2:0] g, input int lim);
        int n;
        for (n = 0; n < lim && lineGain !== g; n++) tick(1);
        check(32'(lineGain), 32'(g));
    endtask
    task dcmIs(input logic e);
        logic [31:0] q;
        rd(12'h00C, q);
        check(32'(q[13]), 32'(e));
    endtask
    task testGain;
        logic [31:0] q;
        lineLevel <= 8'hE8;
        waitGain(3'h6, 8);
        dcmIs(1'b1);
        compWord <= 8'h6A;
        tick(6);
        dcmIs(1'b1);
        compWord <= 8'h78;
        tick(6);
        dcmIs(1'b0);
        compWord <= 8'h50;
        tick(6);
        lineLevel <= 8'h28;
        tick(8);
        check(32'(lineGain), 32'h0000_0006);
        waitGain(3'h2, 200);
        tick(1);
        check(32'(scaledComp), 32'h0000_0190);
        rd(12'h014, q);
        check(q, 32'h0000_0190);
        dcmIs(1'b0);
        lineLevel <= 8'h31;
        waitGain(3'h3, 8);
        lineLevel <= 8'h2D;
        tick(200);
        check(32'(lineGain), 32'h0000_0003);
        wr(12'h000, 32'h0000_6403);
        lineLevel <= 8'h14;
        waitGain(3'h1, 30);
        wr(12'h000, 32'h0000_6401);
    endtask
    task testFault;
        int n;
        for (n = 0; n < 100 && gateDrive !== 1'b1; n++) tick(1);
        check(32'(gateDrive), 32'h0000_0001);
        pinCode <= 8'h27;
        tick(40);
        check(32'(valleyDelay), 32'h0000_0005);
        ocMode <= 1'b1;
        for (n = 0; n < 400 && longFault !== 1'b1; n++) tick(1);
        check(32'(longFault), 32'h0000_0001);
        ocMode <= 1'b0;
        for (n = 0; n < 400 && senseCurrentOn !== 1'b1; n++) tick(1);
        check(32'(senseCurrentOn), 32'h0000_0001);
        for (n = 0; n < 60 && senseCurrentOn === 1'b1; n++) tick(1);
        tick(3);
        check(32'(valleyDelay), 32'h0000_0001);
    endtask
    initial begin
        tick(5);
        reset <= 1'b0;
        tick(1);
        testReset;
        testStartup;
        testAmp;
        testGain;
        testFault;
        printVerdict;
    end
    initial begin
        tick(40000);
        mismatches++;
        printVerdict;
    end
endmodule
bind pfv_core pfv_core_chk #(.SAMPLE_CYC(SAMPLE_CYC)) chk (
    .core_clk(core_clk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
    .valley(valley), .lineGain(lineGain), .valleyDelay(valleyDelay),
    .senseCurrentOn(senseCurrentOn), .gateDrive(gateDrive), .longFault(longFault));
`default_nettype wire
